// file: ldrv_regbank.sv
// led driver control register bank with direct external pulse drive
`timescale 1ns/100ps
module ldrv_regbank #(
    parameter int CW = 20
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_ext_pulse,
    input wire logic [ldrv_pkg::NSTR-1:0] i_engine_drive,
    input wire logic [ldrv_pkg::NSTR-1:0] i_open_status,
    input wire logic [ldrv_pkg::NSTR-1:0] i_short_status,
    input wire logic [ldrv_pkg::NFLAG-1:0] i_fault_flags,
    input wire logic i_fault_pin,
    input wire logic [23:0] i_opt_dac,
    input wire logic [7:0] i_opt_state,
    output logic [ldrv_pkg::NSTR-1:0] o_string_drive,
    output logic o_sleep,
    output logic o_foldback_enable,
    output logic [ldrv_pkg::SCDLY_W-1:0] o_short_detect_delay,
    output logic [ldrv_pkg::FSRC_W-1:0] o_fault_source_enable,
    output logic [ldrv_pkg::NSTR-1:0] o_string_fault_on,
    output logic [ldrv_pkg::OSC_W-1:0] o_oscillator_select,
    output logic [ldrv_pkg::MUL_W-1:0] o_line_sync_multiplier,
    output logic [7:0] o_line_sync_divider
);
    import ldrv_pkg::*;

    // the frame counter must hold a full pulse period
    if (CW < 8 || CW > 30) begin : g_chk
        $error("ldrv_regbank: CW out of range");
    end

    ldrv_link_if lk();

    // serial slave runs on the link clock
    ldrv_spi u_spi (
        .i_resetn(i_resetn),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_mosi(i_mosi),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe),
        .lk(lk)
    );

    // pins except the engine drive, and the request toggle, cross through two flops
    localparam int SW = 3 + 1 + NFLAG + 2 * NSTR + 24 + 8;
    logic [SW-1:0] raw;
    logic [SW-1:0] s;
    assign raw = {lk.req_tgl, i_enable, i_ext_pulse, i_fault_pin,
                  i_fault_flags, i_open_status, i_short_status,
                  i_opt_dac, i_opt_state};

    ldrv_sync #(.W(SW)) u_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_d(raw),
        .o_q(s)
    );

    logic tgl_s;
    logic en_s;
    logic p;
    logic fpin_s;
    logic [NFLAG-1:0] flags_s;
    logic [NSTR-1:0] open_s;
    logic [NSTR-1:0] short_s;
    logic [23:0] dac_s;
    logic [7:0] ostate_s;
    assign {tgl_s, en_s, p, fpin_s, flags_s, open_s, short_s,
            dac_s, ostate_s} = s;

    // edge memories for the request toggle and the enable level
    logic tgl_q;
    logic en_q;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tgl_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            tgl_q <= tgl_s;
            en_q <= en_s;
        end
    end

    logic req;
    logic en_rise;
    logic wr_go;
    logic rd_go;
    assign req = tgl_s ^ tgl_q;
    assign en_rise = en_s & ~en_q;
    // requests landing while disabled are dropped, not queued
    assign wr_go = req & en_s & ~lk.rw;
    assign rd_go = req & en_s & lk.rw;

    ldrv_byte_t regs [NREG];
    ldrv_byte_t nvm [NREG];
    ldrv_byte_t nvm_addr;
    ldrv_byte_t nvm_wval;
    ldrv_idx_t widx;
    ldrv_idx_t nidx;
    assign widx = ldrv_lookup(lk.addr);
    assign nidx = ldrv_lookup(nvm_addr);
    assign nvm_wval = lk.wdata & REG_WMASK[nidx];

    // live registers: boot copy wins over a write in the same cycle
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= REG_DEFAULT[i];
            end
        end else if (en_rise) begin
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= nvm[i];
            end
        end else if (wr_go && widx != IDX_NONE) begin
            // masked store: status slots and unused bits stay zero
            regs[widx] <= lk.wdata & REG_WMASK[widx];
        end
    end

    // nonvolatile shadow of every default, programmed through the data port
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < NREG; i++) begin
                nvm[i] <= REG_DEFAULT[i];
            end
        end else if (wr_go && lk.addr == A_NVM_DATA && nidx != IDX_NONE) begin
            nvm[nidx] <= nvm_wval;
        end
    end

    // store pointer, a byte address in the register map
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            nvm_addr <= NVM_ADDR_RST;
        end else if (wr_go && lk.addr == A_NVM_ADDR) begin
            nvm_addr <= lk.wdata;
        end
    end

    // what software sees: stored bytes with live status laid over them
    ldrv_byte_t view [NREG];
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            view[i] = regs[i];
        end
        view[I_FLT_STAT] = {fpin_s, 2'h0, flags_s};
        view[I_OC_LO] = open_s[7:0];
        view[I_OC_HI] = open_s[15:8];
        view[I_SC_LO] = short_s[7:0];
        view[I_SC_HI] = short_s[15:8];
        view[I_DAC_A] = dac_s[7:0];
        view[I_DAC_B] = dac_s[15:8];
        view[I_DAC_C] = dac_s[23:16];
        view[I_OPT_STATE] = ostate_s;
    end

    // read answer, held until the next read so the link can sample it late
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lk.rdata <= 8'h00;
        end else if (rd_go) begin
            if (lk.addr == A_NVM_ADDR) begin
                lk.rdata <= nvm_addr;
            end else if (lk.addr == A_NVM_DATA) begin
                lk.rdata <= (nidx == IDX_NONE) ? 8'h00 : nvm[nidx];
            end else if (widx == IDX_NONE) begin
                lk.rdata <= 8'h00;
            end else begin
                lk.rdata <= view[widx];
            end
        end
    end

    // configuration outputs, all taken from register flops
    logic [NSTR-1:0] str_en;
    assign str_en = {regs[I_STREN_HI], regs[I_STREN_LO]};
    assign o_sleep = regs[I_CFG][B_SLEEP];
    assign o_foldback_enable = regs[I_CFG][B_FOLDBACK];
    assign o_short_detect_delay = regs[I_CFG][SCDLY_W-1:0];
    assign o_fault_source_enable = regs[I_FSRC][FSRC_W-1:0];
    assign o_string_fault_on = {regs[I_SFEN_HI], regs[I_SFEN_LO]};
    assign o_oscillator_select = regs[I_OSC][OSC_W-1:0];
    assign o_line_sync_multiplier = regs[I_LS_MUL][MUL_W-1:0];
    assign o_line_sync_divider = regs[I_LS_DIV];

    // pulse frame measure: period and high time of the last whole frame
    logic p_q;
    logic [CW-1:0] pos;
    logic [CW-1:0] hcnt;
    logic [CW-1:0] period;
    logic [CW-1:0] high;
    logic [CW-1:0] step;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            p_q <= 1'b0;
            pos <= '0;
            hcnt <= '0;
            period <= '0;
            high <= '0;
        end else begin
            p_q <= p;
            if (p && !p_q) begin
                period <= pos + CW'(1);
                high <= hcnt;
                pos <= '0;
                hcnt <= CW'(1);
            end else begin
                // saturate so a stalled pulse cannot wrap into a false frame
                if (pos != '1) begin
                    pos <= pos + CW'(1);
                end
                if (p && hcnt != '1) begin
                    hcnt <= hcnt + CW'(1);
                end
            end
        end
    end

    // one sixteenth of the measured frame
    assign step = period >> PHASE_SHIFT;

    // string is on while its shifted frame position is inside the high time
    function automatic logic phase_on(input logic [CW-1:0] at,
                                      input logic [CW-1:0] off,
                                      input logic [CW-1:0] per,
                                      input logic [CW-1:0] hi);
        logic [CW-1:0] t;
        t = (at >= off) ? at - off : at + per - off;
        return t < hi;
    endfunction

    logic [NSTR-1:0] staggered;
    always_comb begin
        for (int n = 0; n < NSTR; n++) begin
            staggered[n] = phase_on(pos, CW'(n) * step, period, high);
        end
    end

    // drive source select; the sync engine result is unused in direct mode
    logic direct;
    logic stagger_on;
    logic [NSTR-1:0] next_drive;
    assign direct = regs[I_PWM_A][B_EXT_EN] & regs[I_PWM_A][B_DIRECT];
    assign stagger_on = regs[I_PWM_B][B_STAGGER];
    always_comb begin
        if (!direct) begin
            next_drive = i_engine_drive;
        end else if (stagger_on) begin
            next_drive = staggered;
        end else begin
            next_drive = {NSTR{p}};
        end
        next_drive = next_drive & str_en & {NSTR{en_s & ~o_sleep}};
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_string_drive <= '0;
        end else begin
            o_string_drive <= next_drive;
        end
    end

    // checks, all in the core clock domain
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_boot;
        !en_s ##1 en_s;
    endsequence

    sequence s_write_to(ldrv_byte_t a);
        wr_go && lk.addr == a && !en_rise;
    endsequence

    sequence s_direct_live;
        direct && en_s && !o_sleep;
    endsequence

    boot_copy_a: assert property (
        s_boot |=> regs[I_CFG] == $past(nvm[I_CFG]) && regs[I_PWM_A] == $past(nvm[I_PWM_A]))
        else $error("boot copy from store missing");

    off_quiet_a: assert property (
        !en_s |=> $stable(regs[I_CFG]) && $stable(nvm_addr) && $stable(lk.rdata))
        else $error("state changed while disabled");

    enable_store_a: assert property (
        s_write_to(REG_ADDR[I_STREN_LO]) |=> str_en[7:0] == $past(lk.wdata)
            && str_en[15:8] == $past(regs[I_STREN_HI]))
        else $error("string enable write lost");

    osc_width_a: assert property (
        regs[I_OSC][7:3] == 5'h00)
        else $error("oscillator select upper bits set");

    open_read_a: assert property (
        rd_go && widx == I_OC_LO |=> lk.rdata == $past(open_s[7:0]))
        else $error("open status read wrong");

    fault_read_a: assert property (
        rd_go && widx == I_FLT_STAT |=> lk.rdata[B_FAULT_PIN] == $past(fpin_s)
            && lk.rdata[NFLAG-1:0] == $past(flags_s))
        else $error("fault summary read wrong");

    nvm_prog_a: assert property (
        s_write_to(A_NVM_DATA) ##0 nidx != IDX_NONE |=> nvm[$past(nidx)] == $past(nvm_wval))
        else $error("store programming lost");

    status_ro_a: assert property (
        s_write_to(REG_ADDR[I_SC_LO]) |=> regs[I_SC_LO] == 8'h00)
        else $error("status register took a write");

    unmapped_zero_a: assert property (
        rd_go && widx == IDX_NONE && lk.addr != A_NVM_ADDR && lk.addr != A_NVM_DATA
            |=> lk.rdata == 8'h00)
        else $error("unmapped read not zero");

    direct_plain_a: assert property (
        s_direct_live ##0 !stagger_on |=> o_string_drive == ($past(p) ? $past(str_en) : '0))
        else $error("direct drive does not follow pulse");

    engine_path_a: assert property (
        !direct && en_s && !o_sleep
            |=> o_string_drive == ($past(i_engine_drive) & $past(str_en)))
        else $error("engine path not selected");

    stagger_step_a: assert property (
        s_direct_live ##0 stagger_on && str_en[1] && high != '0 && step != '0 && pos == step
            |=> o_string_drive[1])
        else $error("second string not delayed by one phase");

    sleep_dark_a: assert property (
        o_sleep |=> ##1 o_string_drive == '0 || !o_sleep)
        else $error("drive active during sleep");
endmodule

// file: ldrv_pkg.sv
// shared constants, register map and lookup for the led driver register bank
// Behaviour
// - both external drive bits of primary control set means strings follow pulse input.
// - direct drive ignores frame and line sync timing; pulse alone sets duty.
// - secondary control bit 0 enables stagger; cleared means no added delay.
// - stagger measures pulse frame, each next string delayed another sixteenth.
// - control registers decode over byte addresses 0x00 to 0x2E.
// - two extra registers at 0xC0 and 0xC1 reach the nonvolatile store.
// - nonvolatile store holds every register default; host may rewrite any.
// - rising enable copies the nonvolatile store into all control registers.
// - serial traffic is ignored while enable is low.
// - two string enable registers, string n at bit n.
// - configuration holds sleep, foldback enable and 3-bit short detect delay.
// - fault enable register holds six fault source enables, bits 5 to 0.
// - two per-string fault enable registers, lowest string at bit 0.
// - fault summary shows fault pin state at bit 7, five flags below.
// - two open-circuit status registers, one bit per string.
// - two short-circuit status registers, one bit per string.
// - oscillator select is a 3-bit field; upper bits unused.
// - line sync multiplier is 5 bits, divider 8 bits.
package ldrv_pkg;
    typedef logic [7:0] ldrv_byte_t;
    typedef logic [4:0] ldrv_idx_t;

    localparam int NSTR = 16;
    localparam int NREG = 26;
    localparam ldrv_idx_t IDX_NONE = 5'h1A;

    // register slots, in map order
    localparam ldrv_idx_t I_STREN_LO = 5'h00;
    localparam ldrv_idx_t I_STREN_HI = 5'h01;
    localparam ldrv_idx_t I_CFG = 5'h02;
    localparam ldrv_idx_t I_FSRC = 5'h03;
    localparam ldrv_idx_t I_SFEN_LO = 5'h04;
    localparam ldrv_idx_t I_SFEN_HI = 5'h05;
    localparam ldrv_idx_t I_FLT_STAT = 5'h06;
    localparam ldrv_idx_t I_OC_LO = 5'h07;
    localparam ldrv_idx_t I_OC_HI = 5'h08;
    localparam ldrv_idx_t I_SC_LO = 5'h09;
    localparam ldrv_idx_t I_SC_HI = 5'h0A;
    localparam ldrv_idx_t I_OSC = 5'h0B;
    localparam ldrv_idx_t I_DAC_A = 5'h0F;
    localparam ldrv_idx_t I_DAC_B = 5'h10;
    localparam ldrv_idx_t I_DAC_C = 5'h11;
    localparam ldrv_idx_t I_OPT_STATE = 5'h12;
    localparam ldrv_idx_t I_LS_MUL = 5'h16;
    localparam ldrv_idx_t I_LS_DIV = 5'h17;
    localparam ldrv_idx_t I_PWM_A = 5'h18;
    localparam ldrv_idx_t I_PWM_B = 5'h19;

    localparam ldrv_byte_t REG_ADDR [NREG] = '{
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0A, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h16, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h2D, 8'h2E};
    // writable bits; zero mask marks a status slot
    localparam ldrv_byte_t REG_WMASK [NREG] = '{
        8'hFF, 8'hFF, 8'h8F, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h8F, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h09};
    localparam ldrv_byte_t REG_DEFAULT [NREG] = '{
        8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    localparam ldrv_byte_t A_NVM_ADDR = 8'hC0;
    localparam ldrv_byte_t A_NVM_DATA = 8'hC1;
    localparam ldrv_byte_t NVM_ADDR_RST = 8'h00;

    // field positions and widths
    localparam int B_EXT_EN = 0;
    localparam int B_DIRECT = 1;
    localparam int B_STAGGER = 0;
    localparam int B_SLEEP = 7;
    localparam int B_FOLDBACK = 3;
    localparam int B_FAULT_PIN = 7;
    localparam int SCDLY_W = 3;
    localparam int FSRC_W = 6;
    localparam int OSC_W = 3;
    localparam int MUL_W = 5;
    localparam int NFLAG = 5;

    // stagger splits the frame into this many phases
    localparam int PHASES = 16;
    localparam int PHASE_SHIFT = $clog2(PHASES);

    // serial frame: command byte, address byte, data byte
    localparam int CMD_READ_BIT = 7;
    localparam logic [4:0] CMD_END = 5'd7;
    localparam logic [4:0] ADDR_END = 5'd15;
    localparam logic [4:0] DATA_END = 5'd23;
    localparam logic [4:0] FRAME_BITS = 5'd24;

    // byte address to register slot, IDX_NONE when nothing lives there
    function automatic ldrv_idx_t ldrv_lookup(input ldrv_byte_t a);
        ldrv_idx_t r;
        r = IDX_NONE;
        for (int i = 0; i < NREG; i++) begin
            if (REG_ADDR[i] == a) begin
                r = ldrv_idx_t'(i);
            end
        end
        return r;
    endfunction
endpackage

// file: ldrv_link_if.sv
// carrier between the serial link domain and the core register domain
`timescale 1ns/100ps
interface ldrv_link_if;
    logic req_tgl;
    logic rw;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport link (output req_tgl, rw, addr, wdata, input rdata);
    modport core (input req_tgl, rw, addr, wdata, output rdata);
endinterface

// file: ldrv_sync.sv
// two-flop level synchroniser into the core clock
`timescale 1ns/100ps
module ldrv_sync #(
    parameter int W = 1
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= '0;
            o_q <= '0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

// file: ldrv_spi.sv
// serial slave on the link clock: frame decode and read data shift-out
`timescale 1ns/100ps
module ldrv_spi (
    input wire logic i_resetn,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    ldrv_link_if.link lk
);
    import ldrv_pkg::*;

    logic [4:0] cnt;
    logic [6:0] sh;
    ldrv_byte_t rx;
    assign rx = {sh, i_mosi};

    // bit counter, cleared by the frame's own select so a stopped clock is harmless
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            cnt <= 5'h00;
        end else if (cnt != FRAME_BITS) begin
            cnt <= cnt + 5'h01;
        end
    end

    // shift in and hand finished requests over by toggle
    always_ff @(posedge i_sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sh <= 7'h00;
            lk.rw <= 1'b0;
            lk.addr <= 8'h00;
            lk.wdata <= 8'h00;
            lk.req_tgl <= 1'b0;
        end else begin
            sh <= rx[6:0];
            if (cnt == CMD_END) begin
                lk.rw <= rx[CMD_READ_BIT];
            end
            if (cnt == ADDR_END) begin
                lk.addr <= rx;
                if (lk.rw) begin
                    lk.req_tgl <= ~lk.req_tgl;
                end
            end
            if (cnt == DATA_END && !lk.rw) begin
                lk.wdata <= rx;
                lk.req_tgl <= ~lk.req_tgl;
            end
        end
    end

    // read data goes out on falling edges, msb first; core holds it stable by then
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
        end else begin
            o_miso <= lk.rdata[~cnt[2:0]];
            o_miso_oe <= lk.rw && cnt > ADDR_END && cnt < FRAME_BITS;
        end
    end
endmodule

// file: ldrv_host.sv
// serial host model: mode 0 master whose clock stands still between frames
`timescale 1ns/100ps
module ldrv_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso,
    input wire logic i_miso_oe
);
    // idle frame select high, clock low
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // one frame: command, address, data; read bits sampled on rising edges
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] got);
        logic [23:0] sh;
        sh = {rd, 7'h00, a, wd};
        got = 8'h00;
        o_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // data byte of a read carries a toggling pattern, not a stale value
            o_mosi = (rd && i < 8) ? ~o_mosi : sh[i];
            #80 o_sclk = 1'b1;
            // an undriven line must never pass for data
            if (i < 8) got[i] = i_miso_oe ? i_miso : 1'bx;
            #80 o_sclk = 1'b0;
        end
        #160 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #160;
    endtask
endmodule

// file: tb.sv
// self-checking bench for the led driver register bank
`timescale 1ns/100ps
module tb;
    import ldrv_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_enable = 1'b1;
    logic i_ext_pulse = 1'b0;
    logic [NSTR-1:0] i_engine_drive = 16'h0000;
    logic [NSTR-1:0] i_open_status = 16'h0000;
    logic [NSTR-1:0] i_short_status = 16'h0000;
    logic [NFLAG-1:0] i_fault_flags = 5'h00;
    logic i_fault_pin = 1'b0;
    logic [23:0] i_opt_dac = 24'h000000;
    logic [7:0] i_opt_state = 8'h00;
    logic sclk, cs_n, mosi, miso, miso_oe, o_sleep, o_foldback_enable;
    logic [NSTR-1:0] o_string_drive, o_string_fault_on;
    logic [2:0] o_short_detect_delay, o_oscillator_select;
    logic [5:0] o_fault_source_enable;
    logic [4:0] o_line_sync_multiplier;
    logic [7:0] o_line_sync_divider, junk;
    int err_count = 0;
    int checks = 0;

    // 100 MHz core clock
    always #5 i_core_clk = ~i_core_clk;

    ldrv_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe));

    ldrv_regbank #(.CW(20)) dut_u (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_enable(i_enable), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_ext_pulse(i_ext_pulse),
        .i_engine_drive(i_engine_drive), .i_open_status(i_open_status), .i_short_status(i_short_status),
        .i_fault_flags(i_fault_flags), .i_fault_pin(i_fault_pin), .i_opt_dac(i_opt_dac),
        .i_opt_state(i_opt_state), .o_string_drive(o_string_drive), .o_sleep(o_sleep),
        .o_foldback_enable(o_foldback_enable), .o_short_detect_delay(o_short_detect_delay),
        .o_fault_source_enable(o_fault_source_enable), .o_string_fault_on(o_string_fault_on),
        .o_oscillator_select(o_oscillator_select), .o_line_sync_multiplier(o_line_sync_multiplier),
        .o_line_sync_divider(o_line_sync_divider));

    task automatic end_of_test;
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(1'b0, a, d, junk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] got;
        host_u.xfer(1'b1, a, 8'h00, got);
        cmp_reg(got, e);
    endtask
    // core side inputs change a fixed delay after the edge, then let sync stages land
    task automatic settle;
        repeat (8) @(posedge i_core_clk);
        #1;
    endtask

    task automatic t_defaults;
        rd_chk(8'h00, 8'hFF);
        rd_chk(8'h2D, 8'h00);
        cmp_out(o_string_drive, 16'h0000);
    endtask
    task automatic t_masks;
        wr(8'h02, 8'hFF);
        rd_chk(8'h02, 8'h8F);
        wr(8'h03, 8'hFF);
        rd_chk(8'h03, 8'h3F);
        wr(8'h0F, 8'hFF);
        rd_chk(8'h0F, 8'h07);
        wr(8'h23, 8'hFF);
        rd_chk(8'h23, 8'h1F);
        wr(8'h24, 8'h96);
        rd_chk(8'h24, 8'h96);
        wr(8'h05, 8'hC3);
        rd_chk(8'h05, 8'hC3);
        wr(8'h0B, 8'hFF);
        rd_chk(8'h0B, 8'h00);
        settle();
        cmp_out(16'({o_sleep, o_foldback_enable, o_short_detect_delay}), 16'h001F);
        cmp_out(16'({o_fault_source_enable, o_line_sync_multiplier, o_oscillator_select}), 16'h3FFF);
        cmp_out(o_string_fault_on, 16'hC300);
        cmp_out(16'(o_line_sync_divider), 16'h0096);
    endtask
    // status slots show live inputs and shrug off writes
    task automatic t_status;
        logic [7:0] ad [7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h13, 8'h16};
        logic [7:0] ex [7] = '{8'h95, 8'h34, 8'h12, 8'h56, 8'h78, 8'hA5, 8'h3C};
        @(posedge i_core_clk);
        #1;
        i_fault_flags = 5'h15;
        i_fault_pin = 1'b1;
        i_open_status = 16'h1234;
        i_short_status = 16'h7856;
        i_opt_dac = 24'hA5A5A5;
        i_opt_state = 8'h3C;
        settle();
        for (int i = 0; i < 7; i++) begin
            wr(ad[i], 8'h00);
            rd_chk(ad[i], ex[i]);
        end
    endtask
    task automatic t_direct;
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h0F);
        @(posedge i_core_clk);
        #1;
        i_engine_drive = 16'h00FF;
        i_ext_pulse = 1'b1;
        settle();
        cmp_out(o_string_drive, 16'h000F);
        wr(8'h2D, 8'h03);
        settle();
        cmp_out(o_string_drive, 16'hFF0F);
        i_ext_pulse = 1'b0;
        settle();
        cmp_out(o_string_drive, 16'h0000);
    endtask
    // 160-cycle pulse frames, 40 high: one phase is 10 cycles; samples sit mid-window
    task automatic t_stagger;
        wr(8'h2E, 8'h01);
        @(posedge i_core_clk);
        #1;
        for (int f = 0; f < 3; f++) begin
            i_ext_pulse = 1'b1;
            repeat (40) @(posedge i_core_clk);
            #1;
            i_ext_pulse = 1'b0;
            if (f < 2) begin
                repeat (120) @(posedge i_core_clk);
                #1;
            end
        end
        repeat (9) @(posedge i_core_clk);
        #1;
        cmp_out(o_string_drive, 16'h000E);
        repeat (80) @(posedge i_core_clk);
        #1;
        cmp_out(o_string_drive, 16'h1E00);
    endtask
    // stored default survives; pin low drops traffic; pin rise reloads every register but keeps the store pointer
    task automatic t_store;
        wr(A_NVM_ADDR, 8'h0F);
        wr(A_NVM_DATA, 8'hFD);
        rd_chk(A_NVM_ADDR, 8'h0F);
        rd_chk(A_NVM_DATA, 8'h05);
        @(posedge i_core_clk);
        #1;
        i_enable = 1'b0;
        settle();
        rd_chk(8'h00, 8'h05);
        wr(8'h0F, 8'h02);
        wr(A_NVM_ADDR, 8'h02);
        @(posedge i_core_clk);
        #1;
        i_enable = 1'b1;
        settle();
        rd_chk(8'h0F, 8'h05);
        rd_chk(8'h00, 8'hFF);
        cmp_out(16'(o_oscillator_select), 16'h0005);
        rd_chk(A_NVM_ADDR, 8'h0F);
    endtask

    // watchdog well beyond the expected run of about 200 us
    initial begin
        #500000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge i_core_clk);
        #1;
        i_resetn = 1'b1;
        settle();
        t_defaults();
        t_masks();
        t_status();
        t_direct();
        t_stagger();
        t_store();
        end_of_test();
    end
endmodule
